// File: bench/prl_line_model.sv
// Link partner model that sends one short stream on the receive pair.
`timescale 1ns/1ps
module prl_line_model (
    input  wire logic        ref_clk_i,
    input  wire logic        go_i,
    output prl_pkg::prl_rx_s line_rx_o
);
    int   left;
    logic arm;
    initial begin
        left = 0;
        arm = 1'b0;
        line_rx_o = '0;
    end
    // Go is taken on a rising edge so the stream always starts half a cycle later.
    always @(posedge ref_clk_i) begin
        arm <= go_i;
    end
    // Eight dibits 1,2,3,0,..; between streams the dibit flips so stale data never matches.
    always @(negedge ref_clk_i) begin
        if (arm) begin
            left = 8;
        end
        if (left > 0) begin
            line_rx_o = '{dv: 1'b1, er: 1'b0, d: 2'(9 - left)};
            left--;
        end else begin
            line_rx_o = '{dv: 1'b0, er: 1'b0, d: ~line_rx_o.d};
        end
    end
endmodule

// File: bench/tb.sv
// Self-checking bench for the link timing block.
`timescale 1ns/1ps
module tb;
    localparam int LIM = 200;
    localparam int SD_ON = 40;
    localparam int SD_OFF = 20;
    logic core_clk = 1'b0, ref_clk = 1'b0, rst_n = 1'b0, an_en = 1'b0;
    logic energy = 1'b0, loop_en = 1'b0, spd = 1'b1, go = 1'b0;
    logic flp, sd, crs;
    logic [127:0] crs_v, rdv_v, txv_v;
    logic [1:0] rd_v [128], td_v [128];
    prl_pkg::prl_tx_s tx = '0, line_tx;
    prl_pkg::prl_rx_s line_rx, rx;
    int n_errors = 0;
    int checked = 0;

    // The reference clock is offset so its edges never line up with core edges.
    always #20 core_clk = ~core_clk;
    initial begin
        #3.1;
        forever #7.5 ref_clk = ~ref_clk;
    end

    prl_line_model line (.ref_clk_i(ref_clk), .go_i(go), .line_rx_o(line_rx));
    prl_link_timing #(.FLP_BURST_CYC(6250), .FLP_PERIOD_CYC(10000), .SD_ON_CYC(SD_ON),
        .SD_OFF_CYC(SD_OFF), .DEAD_CYC(30)) dut (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .ref_clock_in_i(ref_clk),
        .an_enable_i(an_en), .flp_word_i(16'h0001), .line_energy_i(energy),
        .loopback_i(loop_en), .speed_100_i(spd), .rmii_tx_i(tx), .line_rx_i(line_rx),
        .flp_pulse_o(flp), .signal_detect_o(sd), .line_tx_o(line_tx),
        .rmii_rx_o(rx), .crs_dv_o(crs));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask
    task automatic close_out();
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic int first(input logic [127:0] v);
        for (int i = 0; i < 128; i++) begin
            if (v[i] === 1'b1) return i;
        end
        return 128;
    endfunction
    // One dibit from the MAC, or one line stream, then 128 edges of outputs logged.
    task automatic rec(input logic [1:0] d, input logic line);
        @(negedge ref_clk);
        tx = '{en: !line, d: d};
        go = line;
        for (int i = 0; i < 128; i++) begin
            @(posedge ref_clk);
            #1;
            crs_v[i] = crs;
            rdv_v[i] = rx.dv;
            rd_v[i] = rx.d;
            txv_v[i] = line_tx.en;
            td_v[i] = line_tx.d;
            if (i == 0) begin
                @(negedge ref_clk);
                tx.en = 1'b0;
                go = 1'b0;
            end
        end
    endtask
    task automatic wait_sd(input logic lvl, output int n);
        n = 0;
        while (sd !== lvl && n < LIM) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= LIM) begin
            n_errors++;
            close_out();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_tx();
        rec(2'h2, 1'b0);
        check("tx latency", prl_pkg::TX_LAT_CYC, first(txv_v));
        check("tx dibit", 2'h2, td_v[prl_pkg::TX_LAT_CYC]);
    endtask
    task automatic t_rx();
        rec(2'h0, 1'b1);
        // Edge 1 is the first to sample the stream; edge 9 the first to miss it.
        check("crs on", prl_pkg::CRS_ON_CYC, first(crs_v));
        check("rx valid on", prl_pkg::RX_LAT_CYC, first(rdv_v));
        check("rx dibit 1", 2'h1, rd_v[prl_pkg::RX_LAT_CYC]);
        check("rx dibit 2", 2'h2, rd_v[1 + prl_pkg::RX_LAT_CYC]);
        check("crs off", 0, crs_v[8 + prl_pkg::CRS_OFF_CYC]);
        check("crs toggle", 1, crs_v[9 + prl_pkg::CRS_OFF_CYC]);
        check("rx valid off", 0, rdv_v[8 + prl_pkg::RX_LAT_CYC]);
    endtask
    // Detect must need the full hold time and must never rise at 10 Mb/s.
    task automatic t_sd();
        int n;
        @(negedge core_clk);
        energy = 1'b1;
        wait_sd(1'b1, n);
        check("detect on", 1, n >= SD_ON && n <= SD_ON + 5);
        @(negedge core_clk);
        energy = 1'b0;
        wait_sd(1'b0, n);
        check("detect off", 1, n >= SD_OFF && n <= SD_OFF + 5);
        @(negedge core_clk);
        spd = 1'b0;
        energy = 1'b1;
        repeat (100) @(negedge core_clk);
        check("detect 10M", 0, sd);
        energy = 1'b0;
        spd = 1'b1;
    endtask
    task automatic t_loop();
        @(negedge core_clk);
        loop_en = 1'b1;
        repeat (5) @(negedge core_clk);
        rec(2'h3, 1'b0);
        check("dead time", 0, {31'h0, |rdv_v[39:0]});
        repeat (40) @(negedge core_clk);
        rec(2'h3, 1'b0);
        // The sampling edge is edge 0, so the last allowed edge is one short of the count.
        check("loop100", prl_pkg::LOOP100_CYC - 1, first(rdv_v));
        check("loop100 crs", prl_pkg::LOOP100_CYC - 1, first(crs_v));
        check("loop dibit", 2'h3, rd_v[prl_pkg::LOOP100_CYC - 1]);
        @(negedge core_clk);
        spd = 1'b0;
        repeat (10) @(negedge core_clk);
        rec(2'h1, 1'b0);
        check("loop10", prl_pkg::LOOP10_CYC - 1, first(rdv_v));
        @(negedge core_clk);
        loop_en = 1'b0;
        spd = 1'b1;
    endtask
    // Word 0001: clock pulses at 0, 3125, 6250, one data pulse, next burst at 10000.
    task automatic t_flp();
        int r[$];
        int w;
        logic prev;
        w = 0;
        prev = 1'b0;
        @(negedge core_clk);
        an_en = 1'b1;
        for (int i = 0; i < 10010; i++) begin
            @(posedge core_clk);
            #1;
            if (flp === 1'b1 && prev === 1'b0) r.push_back(i);
            if (i < 1000) w += flp;
            prev = flp;
        end
        @(negedge core_clk);
        an_en = 1'b0;
        check("pulse width", prl_pkg::FLP_PULSE_CYC, w);
        check("pulse count", 5, r.size());
        check("first pulse", 1, r[0]);
        check("data pulse", prl_pkg::FLP_DATA_CYC, r[1] - r[0]);
        check("clock period", prl_pkg::FLP_CLK_CYC, r[2] - r[0]);
        check("burst width", 6250, r[3] - r[0]);
        check("burst period", 10000, r[4] - r[0]);
    endtask

    initial begin
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge core_clk);
        t_tx();
        t_rx();
        t_sd();
        t_loop();
        t_flp();
        close_out();
    end
endmodule

// File: logic/prl_delay.sv
// Fixed-depth register pipeline used for every latency path of the link.
`timescale 1ns/1ps
module prl_delay #(
    parameter int W     = 4,
    parameter int DEPTH = 2
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] din_i,
    output logic      [W-1:0] dout_o
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] pipe;
    } prl_dly_s;

    prl_dly_s st;
    prl_dly_s next_st;

    // Each stage takes the one before it; stage zero takes the input.
    always_comb begin
        next_st.pipe[0] = din_i;
        for (int i = 1; i < DEPTH; i++) begin
            next_st.pipe[i] = st.pipe[i-1];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout_o = st.pipe[DEPTH-1];

endmodule

// File: logic/prl_link_timing.sv
// Link pulse bursts, signal detect, loopback and RMII latency paths of a 10/100 PHY.
//
// Notes on behaviour
// - Every clock and data pulse of a burst is about 100 ns wide.
// - Clock pulses inside a burst are spaced 125 us apart.
// - A one bit adds a data pulse 62 us after its clock pulse.
// - A burst spans 2 ms; bursts start every 16 ms.
// - Signal detect rises within 1 ms and falls within 350 us.
// - 100M loopback: receive valid within 240 ns of the sampling edge.
// - Entering 100M loopback, receive side stays silent for up to 550 us.
// - 10M loopback: receive valid within 2 us of the sampling edge.
// - The reference clock is 50 MHz and times every RMII transfer.
// - Transmit dibit and enable are sampled on the reference rising edge.
// - First line bit leaves about 17 bit times after the sampling edge.
// - Receive outputs change only on the reference rising edge.
// - Carrier/valid rises about 18.5 bit times after start of stream.
// - Carrier/valid falls about 27 bit times after end of stream.
// - Receive data and error emerge about 38 bit times after arrival.
// - Carrier/valid asserts without waiting for a further clock edge; in loopback the code drives it from the registered receive valid.
// - After carrier drops, carrier/valid toggles while buffered data drains.
// - A separate synchronous receive valid is driven alongside the RMII set.
// - At 100 Mb/s one bit time counts as 10 ns.
`timescale 1ns/1ps
module prl_link_timing #(
    parameter int FLP_BURST_CYC  = prl_pkg::FLP_BURST_CYC,
    parameter int FLP_PERIOD_CYC = prl_pkg::FLP_PERIOD_CYC,
    parameter int SD_ON_CYC      = prl_pkg::SD_ON_CYC,
    parameter int SD_OFF_CYC     = prl_pkg::SD_OFF_CYC,
    parameter int DEAD_CYC       = prl_pkg::DEAD_CYC
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ref_clock_in_i,
    input  wire logic             an_enable_i,
    input  wire logic [15:0]      flp_word_i,
    input  wire logic             line_energy_i,
    input  wire logic             loopback_i,
    input  wire logic             speed_100_i,
    input  wire prl_pkg::prl_tx_s rmii_tx_i,
    input  wire prl_pkg::prl_rx_s line_rx_i,
    output logic                  flp_pulse_o,
    output logic                  signal_detect_o,
    output prl_pkg::prl_tx_s      line_tx_o,
    output prl_pkg::prl_rx_s      rmii_rx_o,
    output logic                  crs_dv_o
);

    localparam int CW = prl_pkg::CW;
    localparam logic [11:0] SLOT_END_L  = 12'(prl_pkg::FLP_CLK_CYC - 1);
    localparam logic [11:0] PULSE_L     = 12'(prl_pkg::FLP_PULSE_CYC);
    localparam logic [11:0] DATA_L      = 12'(prl_pkg::FLP_DATA_CYC);
    localparam logic [4:0]  WORD_BITS_L = 5'(prl_pkg::FLP_WORD_BITS);
    localparam logic [CW-1:0] BURST_END_L =
        CW'(FLP_BURST_CYC + prl_pkg::FLP_PULSE_CYC - 1);
    localparam logic [CW-1:0] PERIOD_L  = CW'(FLP_PERIOD_CYC - 1);
    localparam logic [CW-1:0] SD_ON_L   = CW'(SD_ON_CYC - 1);
    localparam logic [CW-1:0] SD_OFF_L  = CW'(SD_OFF_CYC - 1);
    localparam logic [CW-1:0] DEAD_L    = CW'(DEAD_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release, one synchroniser per clock domain.
    logic [1:0] core_rst_q;
    logic [1:0] link_rst_q;
    logic       core_rst_n;
    logic       link_rst_n;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_rst_q <= 2'h0;
        end else begin
            core_rst_q <= {core_rst_q[0], 1'b1};
        end
    end

    always_ff @(posedge ref_clock_in_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_rst_q <= 2'h0;
        end else begin
            link_rst_q <= {link_rst_q[0], 1'b1};
        end
    end

    assign core_rst_n = core_rst_q[1];
    assign link_rst_n = link_rst_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Core domain: burst generator, signal qualification, loopback dead time.
    typedef struct packed {
        logic [2:0]        pin_s1;
        logic [2:0]        pin_s2;
        prl_pkg::prl_flp_e flp_state;
        logic [CW-1:0]     burst_cnt;
        logic [11:0]       slot_cnt;
        logic [4:0]        bit_idx;
        logic              flp_pulse;
        logic [CW-1:0]     sd_cnt;
        logic              sd;
        logic [CW-1:0]     dead_cnt;
        logic              dead_done;
        logic [2:0]        lb;
    } prl_core_s;

    prl_core_s core;
    prl_core_s next_core;
    logic      sd_raw;
    logic      loop100;

    // Pin order in the synchroniser: energy, loopback, speed.
    assign sd_raw  = core.pin_s2[2] & core.pin_s2[0];
    assign loop100 = core.pin_s2[1] & core.pin_s2[0];

    // One pass computes every next value of the core state.
    always_comb begin
        next_core        = core;
        next_core.pin_s1 = {line_energy_i, loopback_i, speed_100_i};
        next_core.pin_s2 = core.pin_s1;
        case (core.flp_state)
            prl_pkg::PRL_FLP_IDLE: begin
                next_core.burst_cnt = '0;
                next_core.slot_cnt  = '0;
                next_core.bit_idx   = '0;
                if (an_enable_i) begin
                    next_core.flp_state = prl_pkg::PRL_FLP_BURST;
                end
            end
            prl_pkg::PRL_FLP_BURST: begin
                next_core.burst_cnt = core.burst_cnt + 1'b1;
                if (core.slot_cnt == SLOT_END_L) begin
                    next_core.slot_cnt = '0;
                    next_core.bit_idx  = core.bit_idx + 1'b1;
                end else begin
                    next_core.slot_cnt = core.slot_cnt + 1'b1;
                end
                if (core.burst_cnt == BURST_END_L) begin
                    next_core.flp_state = prl_pkg::PRL_FLP_WAIT;
                end
            end
            prl_pkg::PRL_FLP_WAIT: begin
                next_core.burst_cnt = core.burst_cnt + 1'b1;
                if (core.burst_cnt == PERIOD_L) begin
                    next_core.burst_cnt = '0;
                    next_core.slot_cnt  = '0;
                    next_core.bit_idx   = '0;
                    next_core.flp_state = an_enable_i ? prl_pkg::PRL_FLP_BURST
                                                      : prl_pkg::PRL_FLP_IDLE;
                end
            end
            default: begin
                next_core.flp_state = prl_pkg::PRL_FLP_IDLE;
            end
        endcase
        // Clock pulse opens each slot; a one bit adds a pulse mid-slot.
        next_core.flp_pulse = (core.flp_state == prl_pkg::PRL_FLP_BURST) &&
            ((core.slot_cnt < PULSE_L) ||
             ((core.bit_idx < WORD_BITS_L) && flp_word_i[core.bit_idx[3:0]] &&
              (core.slot_cnt >= DATA_L) && (core.slot_cnt < DATA_L + PULSE_L)));
        // Detect follows the line only after the level has held long enough.
        if (sd_raw != core.sd) begin
            if (core.sd_cnt == (sd_raw ? SD_ON_L : SD_OFF_L)) begin
                next_core.sd     = sd_raw;
                next_core.sd_cnt = '0;
            end else begin
                next_core.sd_cnt = core.sd_cnt + 1'b1;
            end
        end else begin
            next_core.sd_cnt = '0;
        end
        // Dead time restarts whenever 100M loopback is left.
        if (!loop100) begin
            next_core.dead_cnt  = '0;
            next_core.dead_done = 1'b0;
        end else if (!core.dead_done) begin
            if (core.dead_cnt == DEAD_L) begin
                next_core.dead_done = 1'b1;
            end else begin
                next_core.dead_cnt = core.dead_cnt + 1'b1;
            end
        end
        // Loopback levels: 100M live, 10M live, 100M in dead time.
        next_core.lb = {loop100 & core.dead_done,
                        core.pin_s2[1] & ~core.pin_s2[0],
                        loop100 & ~core.dead_done};
    end

    always_ff @(posedge core_clk_i or negedge core_rst_n) begin
        if (!core_rst_n) begin
            core <= '0;
        end else begin
            core <= next_core;
        end
    end

    assign flp_pulse_o     = core.flp_pulse;
    assign signal_detect_o = core.sd;

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain on the reference clock: sampling, latency lines, receive outputs.
    typedef struct packed {
        logic [2:0]       lb_s1;
        logic [2:0]       lb_s2;
        prl_pkg::prl_tx_s tx;
        prl_pkg::prl_rx_s rx;
        logic             crs_tgl;
    } prl_link_s;

    prl_link_s        link;
    prl_link_s        next_link;
    prl_pkg::prl_rx_s rx_line_dly;
    prl_pkg::prl_rx_s rx_l100_dly;
    prl_pkg::prl_rx_s rx_l10_dly;
    prl_pkg::prl_rx_s loop_src;
    logic             crs_on_dly;
    logic             crs_off_dly;
    logic             carrier;

    assign loop_src = '{dv: link.tx.en, er: 1'b0, d: link.tx.d};
    assign carrier  = crs_on_dly | crs_off_dly;

    // Loopback levels cross as plain levels; a stray cycle only delays the switch.
    always_comb begin
        next_link       = link;
        next_link.lb_s1 = core.lb;
        next_link.lb_s2 = link.lb_s1;
        next_link.tx    = rmii_tx_i;
        if (link.lb_s2[2]) begin
            next_link.rx = rx_l100_dly;
        end else if (link.lb_s2[1]) begin
            next_link.rx = rx_l10_dly;
        end else if (link.lb_s2[0]) begin
            next_link.rx = '0;
        end else begin
            next_link.rx = rx_line_dly;
        end
        next_link.crs_tgl = (!carrier && link.rx.dv) ? !link.crs_tgl : 1'b0;
    end

    // All RMII-side state runs on the 50 MHz reference clock.
    always_ff @(posedge ref_clock_in_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    prl_delay #(.W(3), .DEPTH(prl_pkg::TX_LAT_CYC)) u_tx_dly (
        .clk_i   (ref_clock_in_i),
        .rst_n_i (link_rst_n),
        .din_i   (link.tx),
        .dout_o  (line_tx_o)
    );

    prl_delay #(.W(4), .DEPTH(prl_pkg::RX_DEPTH)) u_rx_dly (
        .clk_i   (ref_clock_in_i),
        .rst_n_i (link_rst_n),
        .din_i   (line_rx_i),
        .dout_o  (rx_line_dly)
    );

    prl_delay #(.W(1), .DEPTH(prl_pkg::CRS_ON_CYC)) u_crs_on (
        .clk_i   (ref_clock_in_i),
        .rst_n_i (link_rst_n),
        .din_i   (line_rx_i.dv),
        .dout_o  (crs_on_dly)
    );

    prl_delay #(.W(1), .DEPTH(prl_pkg::CRS_OFF_CYC)) u_crs_off (
        .clk_i   (ref_clock_in_i),
        .rst_n_i (link_rst_n),
        .din_i   (line_rx_i.dv),
        .dout_o  (crs_off_dly)
    );

    prl_delay #(.W(4), .DEPTH(prl_pkg::LOOP100_DEPTH)) u_l100 (
        .clk_i   (ref_clock_in_i),
        .rst_n_i (link_rst_n),
        .din_i   (loop_src),
        .dout_o  (rx_l100_dly)
    );

    prl_delay #(.W(4), .DEPTH(prl_pkg::LOOP10_DEPTH)) u_l10 (
        .clk_i   (ref_clock_in_i),
        .rst_n_i (link_rst_n),
        .din_i   (loop_src),
        .dout_o  (rx_l10_dly)
    );

    // Data and valid are registered; outside loopback carrier/valid is gated straight from the taps
    // so its rise costs no output register stage.
    assign rmii_rx_o = link.rx;
    assign crs_dv_o  = (|link.lb_s2) ? link.rx.dv
                                     : (carrier | (link.rx.dv & link.crs_tgl));

    ////////////////////////////////////////////////////////////////////////////////
    // Checks, with helper counters that only the checks read.
    logic              prev_pulse;
    prl_pkg::prl_flp_e prev_state;
    logic [CW-1:0]     clk_gap;
    logic [CW-1:0]     burst_gap;
    logic [CW-1:0]     hi_run;
    logic [CW-1:0]     lo_run;

    always_ff @(posedge core_clk_i or negedge core_rst_n) begin
        if (!core_rst_n) begin
            prev_pulse <= 1'b0;
            prev_state <= prl_pkg::PRL_FLP_IDLE;
            clk_gap    <= '0;
            burst_gap  <= '0;
            hi_run     <= '0;
            lo_run     <= '0;
        end else begin
            prev_pulse <= flp_pulse_o;
            prev_state <= core.flp_state;
            clk_gap    <= (flp_pulse_o && !prev_pulse && core.slot_cnt == 12'h001)
                          ? CW'(1) : clk_gap + 1'b1;
            burst_gap  <= (core.flp_state == prl_pkg::PRL_FLP_BURST &&
                           prev_state != prl_pkg::PRL_FLP_BURST) ? CW'(1) : burst_gap + 1'b1;
            hi_run     <= sd_raw ? ((&hi_run) ? hi_run : hi_run + 1'b1) : '0;
            lo_run     <= !sd_raw ? ((&lo_run) ? lo_run : lo_run + 1'b1) : '0;
        end
    end

    sequence s_pulse_high;
        flp_pulse_o [*3] ##1 !flp_pulse_o;
    endsequence

    sequence s_tx_taken;
        $rose(link.tx.en);
    endsequence

    chk_flp_width: assert property (@(posedge core_clk_i) disable iff (!core_rst_n)
        $rose(flp_pulse_o) |-> s_pulse_high) else $error("burst pulse width wrong");
    chk_flp_clock: assert property (@(posedge core_clk_i) disable iff (!core_rst_n)
        $rose(flp_pulse_o) && core.slot_cnt == 12'h001 && core.bit_idx != 5'h00
        |-> clk_gap == CW'(prl_pkg::FLP_CLK_CYC)) else $error("clock pulse spacing wrong");
    chk_flp_data: assert property (@(posedge core_clk_i) disable iff (!core_rst_n)
        $rose(flp_pulse_o) && core.slot_cnt != 12'h001
        |-> clk_gap == CW'(prl_pkg::FLP_DATA_CYC)) else $error("data pulse offset wrong");
    chk_flp_period: assert property (@(posedge core_clk_i) disable iff (!core_rst_n)
        core.flp_state == prl_pkg::PRL_FLP_BURST && prev_state == prl_pkg::PRL_FLP_WAIT
        |-> burst_gap == CW'(FLP_PERIOD_CYC)) else $error("burst period wrong");
    chk_sd_rise: assert property (@(posedge core_clk_i) disable iff (!core_rst_n)
        sd_raw && hi_run >= CW'(SD_ON_CYC) |-> signal_detect_o)
        else $error("signal detect rose late");
    chk_sd_fall: assert property (@(posedge core_clk_i) disable iff (!core_rst_n)
        !sd_raw && lo_run >= CW'(SD_OFF_CYC) |-> !signal_detect_o)
        else $error("signal detect fell late");
    chk_tx_latency: assert property (@(posedge ref_clock_in_i) disable iff (!link_rst_n)
        s_tx_taken |-> ##9 line_tx_o.en) else $error("line transmit latency wrong");
    chk_loop_fast: assert property (@(posedge ref_clock_in_i) disable iff (!link_rst_n)
        (s_tx_taken and (link.lb_s2 == 3'h4)) |-> ##[1:11] rmii_rx_o.dv)
        else $error("100M loopback valid late");
    chk_loop_slow: assert property (@(posedge ref_clock_in_i) disable iff (!link_rst_n)
        (s_tx_taken and (link.lb_s2 == 3'h2)) |-> ##[1:99] rmii_rx_o.dv)
        else $error("10M loopback valid late");
    chk_dead_quiet: assert property (@(posedge ref_clock_in_i) disable iff (!link_rst_n)
        link.lb_s2 == 3'h1 ##1 link.lb_s2 == 3'h1 |-> !rmii_rx_o.dv && !crs_dv_o)
        else $error("data during loopback dead time");
    chk_crs_on: assert property (@(posedge ref_clock_in_i) disable iff (!link_rst_n)
        $rose(line_rx_i.dv) && !crs_dv_o && link.lb_s2 == 3'h0
        |-> ##1 !crs_dv_o [*8] ##1 crs_dv_o) else $error("carrier rise timing wrong");
    chk_crs_off: assert property (@(posedge ref_clock_in_i) disable iff (!link_rst_n)
        $fell(line_rx_i.dv) |-> ##13 $fell(crs_off_dly)) else $error("carrier fall timing wrong");
    chk_rx_latency: assert property (@(posedge ref_clock_in_i) disable iff (!link_rst_n)
        link.lb_s2 == 3'h0 && $past(link.lb_s2, 19) == 3'h0 && $past(link_rst_n, 19)
        |-> rmii_rx_o.d == $past(line_rx_i.d, 19)) else $error("receive data latency wrong");

endmodule

// File: logic/prl_pkg.sv
// Constants, states and carrier types for the RMII link timing block.
package prl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock rates and bit time.
    localparam int CORE_MHZ   = 25;
    localparam int REF_MHZ    = 50;
    localparam int REF_NS     = 1000 / REF_MHZ;
    localparam int BIT_NS_100 = 10;
    localparam int CW         = 20;

    ////////////////////////////////////////////////////////////////////////////////
    // Link pulse burst times in their printed units and the derived core cycles.
    localparam int FLP_PULSE_NS   = 100;
    localparam int FLP_CLK_US     = 125;
    localparam int FLP_DATA_US    = 62;
    localparam int FLP_BURST_MS   = 2;
    localparam int FLP_PERIOD_MS  = 16;
    localparam int FLP_WORD_BITS  = 16;
    localparam int FLP_PULSE_CYC  = (FLP_PULSE_NS * CORE_MHZ + 999) / 1000;
    localparam int FLP_CLK_CYC    = FLP_CLK_US * CORE_MHZ;
    localparam int FLP_DATA_CYC   = FLP_DATA_US * CORE_MHZ;
    localparam int FLP_BURST_CYC  = FLP_BURST_MS * 1000 * CORE_MHZ;
    localparam int FLP_PERIOD_CYC = FLP_PERIOD_MS * 1000 * CORE_MHZ;

    ////////////////////////////////////////////////////////////////////////////////
    // Signal qualification and loopback dead time.
    localparam int SD_ON_MS   = 1;
    localparam int SD_OFF_US  = 350;
    localparam int DEAD_US    = 550;
    localparam int SD_ON_CYC  = SD_ON_MS * 1000 * CORE_MHZ;
    localparam int SD_OFF_CYC = SD_OFF_US * CORE_MHZ;
    localparam int DEAD_CYC   = DEAD_US * CORE_MHZ;

    ////////////////////////////////////////////////////////////////////////////////
    // Link latencies in bit times (tenths where printed with a half), loopback ones in ns or us, and ref cycles.
    localparam int TX_LAT_BITS   = 17;
    localparam int CRS_ON_TENTHS = 185;
    localparam int CRS_OFF_BITS  = 27;
    localparam int RX_LAT_BITS   = 38;
    localparam int LOOP100_NS    = 240;
    localparam int LOOP10_US     = 2;
    localparam int TX_LAT_CYC    = (TX_LAT_BITS * BIT_NS_100 + REF_NS - 1) / REF_NS;
    localparam int CRS_ON_CYC    = (CRS_ON_TENTHS * BIT_NS_100) / (10 * REF_NS);
    localparam int CRS_OFF_CYC   = (CRS_OFF_BITS * BIT_NS_100) / REF_NS;
    localparam int RX_LAT_CYC    = (RX_LAT_BITS * BIT_NS_100) / REF_NS;
    localparam int LOOP100_CYC   = LOOP100_NS / REF_NS;
    localparam int LOOP10_CYC    = (LOOP10_US * 1000) / REF_NS;
    localparam int RX_DEPTH      = RX_LAT_CYC - 1;
    localparam int LOOP100_DEPTH = LOOP100_CYC - 2;
    localparam int LOOP10_DEPTH  = LOOP10_CYC - 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Burst generator states, Gray coded along idle, burst, wait.
    typedef enum logic [1:0] {
        PRL_FLP_IDLE  = 2'h0,
        PRL_FLP_BURST = 2'h1,
        PRL_FLP_WAIT  = 2'h3
    } prl_flp_e;

    // Transmit carrier: enable and dibit.
    typedef struct packed {
        logic       en;
        logic [1:0] d;
    } prl_tx_s;

    // Receive carrier: valid, error and dibit.
    typedef struct packed {
        logic       dv;
        logic       er;
        logic [1:0] d;
    } prl_rx_s;

endpackage
